// ### hw/cef_pkg.sv
// Purpose: Shared constants and types for the charger event and fault control block
// Assumes: 32-bit APB register access, 100 MHz core clock
// Notes:   Register offsets are byte addresses of aligned words
package cef_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] OFF_STATUS  = 8'h00;
  localparam logic [7:0] OFF_FLAG    = 8'h04;
  localparam logic [7:0] OFF_MASK    = 8'h08;
  localparam logic [7:0] OFF_CONTROL = 8'h0c;
  localparam logic [7:0] OFF_ACTION  = 8'h10;

  // ==========================================================
  // Event source bit positions in status, flag and mask words
  localparam int NUM_SRC        = 12;
  localparam int SRC_SRC_GOOD   = 0;
  localparam int SRC_SRC_TYPE   = 1;
  localparam int SRC_IN_CUR_REG = 2;
  localparam int SRC_IN_VLT_REG = 3;
  localparam int SRC_THERM_REG  = 4;
  localparam int SRC_WATCHDOG   = 5;
  localparam int SRC_CHG_STATE  = 6;
  localparam int SRC_THERM_ST   = 7;
  localparam int SRC_IN_OV      = 8;
  localparam int SRC_THERMAL_SHUTDOWN      = 9;
  localparam int SRC_BAT_OV     = 10;
  localparam int SRC_SAFE_TMR   = 11;
  localparam int SRC_SYS_SHORT  = 12;
  localparam int SRC_RB_FAULT   = 13;
  localparam int SRC_W          = 14;

  // Control register fields
  localparam int CTL_CURRENT_LIMIT_PIN_EN = 0;
  localparam int CTL_RB_EN   = 1;
  localparam logic [31:0] CTL_RESET = 32'h0000_0001;

  // ==========================================================
  // Timing
  localparam int  CLK_HZ        = 100_000_000;
  localparam int  ALERT_US      = 256;
  localparam int  ALERT_CYCLES  = (CLK_HZ / 1_000_000) * ALERT_US;
  localparam logic [1:0] RESP_OKAY = 2'h0;

  // Analog comparator inputs
  typedef struct packed {
    logic       src_good;
    logic [2:0] input_source_type;
    logic       input_current_regulation;
    logic       current_limit_pin;
    logic       input_voltage_regulation;
    logic       thermal_regulation;
    logic       watchdog_expired;
    logic [1:0] charge_state;
    logic [2:0] thermistor_state;
    logic       input_overvoltage;
    logic       thermal_shutdown;
    logic       battery_overvoltage;
    logic       safety_timer_expired;
    logic       system_overvoltage;
    logic       system_short;
    logic       output_overvoltage;
    logic       output_short;
    logic       battery_overdischarge;
    logic       battery_short_band;
  } cef_sense_t;

  // Protective actions
  typedef struct packed {
    logic converter_run;
    logic charge_enable;
    logic termination_enable;
    logic safety_timer_half;
    logic battery_switch;
    logic use_short_current;
    logic use_precharge_current;
    logic current_limit_pin_monitor_enable;
  } cef_action_t;

  typedef enum logic [1:0] {
    ALERT_IDLE  = 2'b00,
    ALERT_PULSE = 2'b01
  } cef_alert_state_t;

endpackage

// ### hw/cef_event_ctrl.sv
// Purpose: Event flags, alert pulse and fault reactions of a battery charger
// Assumes: Sense inputs are synchronous to core_clk; APB slave with zero wait states
// Notes:   One clock, synchronous active-high reset
//          Register map, one aligned word each:
//            0x00 status, live level of each single-bit source, read only
//            0x04 flag, sticky record of events, cleared by a read
//            0x08 mask, a set bit keeps that source off the alert pin
//            0x0c control, bit 0 limit pin enable, bit 1 reverse buck enable
//            0x10 action, copy of the protective outputs
//          Source bits in status, flag and mask:
//            0 source good, 1 source type, 2 input current regulation
//            3 input voltage regulation, 4 thermal regulation, 5 watchdog
//            6 charge state, 7 thermistor state, 8 input overvoltage
//            9 thermal shutdown, 10 battery overvoltage, 11 safety timer
//            12 system short, 13 reverse buck fault
//          Bus timing: a setup cycle, then one access cycle with pready
//            high; read data and the error flag come from flops loaded
//            during setup, so the pins never carry decode glitches
//          Alert: host_alert_n falls one cycle after the event edge and
//            stays low for ALERT_LEN cycles; events meanwhile set flags only
//          Source good and the multi-bit fields flag on any change; the
//            other sources flag on their rising edge only
//          Status and field copies load the live inputs during reset, so
//            releasing reset never shows a false edge; only the power-up
//            marker announces itself
//          Limitation: a level already high when its mask is cleared gives
//            no alert; only a new edge does
//          Limitation: a read of the flag word and a new event in the same
//            cycle keep the new event, but an event in the setup cycle is cleared unread
//
// Behaviour
// - Unmasked event gives one 256 us low pulse
// - Alert on source good, removed, type change
// - Alert entering current, voltage, thermal regulation
// - Alert on watchdog expiry and power-up
// - Alert on charge state, thermistor state change
// - Alert on overvoltage, shutdown, battery OV (charge state not 0), timer
// - Status rising edge triggers masked alert
// - Each source has status, flag, mask; status bits 1, 6 and 7 (type, charge state, thermistor state) read zero
// - Flag stays set after status falls
// - Flag read clears; new edge sets again
// - Limit pin regulation sets status, flag, alert
// - Limit pin ignored when its enable is zero
// - Input overvoltage stops converter outside reverse mode, auto resume
// - Poor source stops converter outside reverse mode, clears good status
// - System overvoltage stops converter immediately outside reverse mode
// - System short stops outside reverse mode, flags, alerts, self recovers
// - Output overvoltage clears reverse buck enable
// - Output short clears reverse buck enable
// - Thermal regulation halves timer, stops termination
// - Charge-mode shutdown stops converter, auto restart
// - Reverse-mode shutdown clears enable; host re-enables
// - Battery overvoltage disables charging immediately
// - Over-discharge opens battery switch until source
`timescale 1ns/1ns
module cef_event_ctrl #(
  parameter int ALERT_LEN = cef_pkg::ALERT_CYCLES
) (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                reset,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // Analog comparator results
  input  wire cef_pkg::cef_sense_t sense,
  // Host alert and protective actions
  output logic                     host_alert_n,
  output cef_pkg::cef_action_t     action,
  output logic                     reverse_buck_enable
);

  // ==========================================================
  // Parameter check
  if (ALERT_LEN < 2) begin : g_bad_len
    $error("ALERT_LEN must be at least 2");
  end

  localparam int CW = $clog2(ALERT_LEN + 1);
  localparam logic [CW-1:0] ALERT_LAST = CW'(ALERT_LEN - 1);
  localparam int SW = cef_pkg::SRC_W;

  // ==========================================================
  // Registers
  logic [SW-1:0]            status_reg;
  logic [SW-1:0]            status_next;
  logic [SW-1:0]            flag_reg;
  logic [SW-1:0]            flag_next;
  logic [SW-1:0]            mask_reg;
  logic                     current_limit_pin_en_reg;
  logic                     rb_en_reg;
  logic                     rb_en_next;
  logic [2:0]               src_type_reg;
  logic [1:0]               chg_state_reg;
  logic [2:0]               therm_state_reg;
  logic                     powerup_reg;
  logic                     batsw_open_reg;
  logic                     batsw_open_next;
  logic [CW-1:0]            cnt_reg;
  cef_pkg::cef_alert_state_t state_reg;
  cef_pkg::cef_alert_state_t state_next;
  logic                     pready_reg;
  logic [31:0]              prdata_reg;
  cef_pkg::cef_action_t     action_next;

  // ==========================================================
  // Bus decode
  wire logic acc      = psel && penable && pready_reg;
  wire logic wr_acc   = acc && pwrite;
  wire logic rd_acc   = acc && !pwrite;
  wire logic hit_flag = paddr == cef_pkg::OFF_FLAG;
  wire logic hit_mask = paddr == cef_pkg::OFF_MASK;
  wire logic hit_ctl  = paddr == cef_pkg::OFF_CONTROL;
  wire logic hit_stat = paddr == cef_pkg::OFF_STATUS;
  wire logic hit_act  = paddr == cef_pkg::OFF_ACTION;
  wire logic hit_any  = hit_flag | hit_mask | hit_ctl | hit_stat | hit_act;

  // Zero-extend a narrow field to a bus word
  function automatic logic [31:0] widen(input logic [SW-1:0] v);
    widen = {{(32 - SW){1'b0}}, v};
  endfunction

  wire logic [31:0] rd_word =
    hit_stat ? widen(status_reg) :
    hit_flag ? widen(flag_reg) :
    hit_mask ? widen(mask_reg) :
    hit_ctl  ? {30'h0, rb_en_reg, current_limit_pin_en_reg} :
    hit_act  ? {24'h0, action} : 32'h0;

  // ==========================================================
  // Live status bits
  // pin gated by enable
  // With the enable low the pin may float high; gating here keeps a
  // floating pin from posing as current regulation.
  wire logic pin_lim  = current_limit_pin_en_reg && sense.current_limit_pin;
  // pin enters current regulation
  // Register limit and pin limit share one source bit, as the host sees
  // no difference between the two causes.
  wire logic icr_live = sense.input_current_regulation | pin_lim;
  wire logic rb_mode  = rb_en_reg;
  // output faults only matter in reverse mode
  wire logic rb_fault = rb_mode && (sense.output_overvoltage || sense.output_short);
  wire logic rb_thermal_shutdown = rb_mode && sense.thermal_shutdown;
  // good source drops on poor source
  wire logic good_live = sense.src_good && !sense.input_overvoltage;

  always_comb begin
    status_next = '0;
    status_next[cef_pkg::SRC_SRC_GOOD]   = good_live;
    status_next[cef_pkg::SRC_IN_CUR_REG] = icr_live;
    status_next[cef_pkg::SRC_IN_VLT_REG] = sense.input_voltage_regulation;
    status_next[cef_pkg::SRC_THERM_REG]  = sense.thermal_regulation;
    status_next[cef_pkg::SRC_WATCHDOG]   = sense.watchdog_expired;
    status_next[cef_pkg::SRC_IN_OV]      = sense.input_overvoltage;
    status_next[cef_pkg::SRC_THERMAL_SHUTDOWN]      = sense.thermal_shutdown;
    status_next[cef_pkg::SRC_BAT_OV]     = sense.battery_overvoltage &&
                                           sense.charge_state != 2'h0;
    status_next[cef_pkg::SRC_SAFE_TMR]   = sense.safety_timer_expired;
    status_next[cef_pkg::SRC_SYS_SHORT]  = sense.system_short;
    status_next[cef_pkg::SRC_RB_FAULT]   = rb_fault;
  end

  // ==========================================================
  // Event detection
  wire logic type_chg  = sense.input_source_type != src_type_reg;
  wire logic chg_chg   = sense.charge_state != chg_state_reg;
  wire logic therm_chg = sense.thermistor_state != therm_state_reg;

  wire logic [SW-1:0] rise = status_next & ~status_reg;
  logic [SW-1:0] evt;
  always_comb begin
    evt = rise;
    evt[cef_pkg::SRC_SRC_GOOD]  = good_live ^ status_reg[cef_pkg::SRC_SRC_GOOD];
    evt[cef_pkg::SRC_SRC_TYPE]  = type_chg;
    evt[cef_pkg::SRC_CHG_STATE] = chg_chg;
    evt[cef_pkg::SRC_THERM_ST]  = therm_chg;
    evt[cef_pkg::SRC_WATCHDOG]  = rise[cef_pkg::SRC_WATCHDOG] | powerup_reg;
  end

  // read clears, set wins over clear
  wire logic flag_clr = rd_acc && hit_flag;
  assign flag_next = (flag_clr ? '0 : flag_reg) | evt;
  wire logic fire = |(evt & ~mask_reg);

  // ==========================================================
  // Alert pulse sequencer
  // new events while pulsing only set flags
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      cef_pkg::ALERT_IDLE:  if (fire) begin
        state_next = cef_pkg::ALERT_PULSE;
      end
      cef_pkg::ALERT_PULSE: if (cnt_reg == ALERT_LAST) begin
        state_next = cef_pkg::ALERT_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Protective reactions
  // faults drop reverse enable; host must set again
  assign rb_en_next = (wr_acc && hit_ctl) ? pwdata[cef_pkg::CTL_RB_EN] :
                      (rb_fault || rb_thermal_shutdown) ? 1'b0 : rb_en_reg;
  // switch opens on over-discharge, closes with a source
  // A present source wins: the battery is still below its floor when the
  // source arrives, and it must be connected to be charged back up.
  assign batsw_open_next = sense.src_good ? 1'b0 :
                           sense.battery_overdischarge ? 1'b1 : batsw_open_reg;

  // Boost-side faults that halt switching until they clear by themselves
  wire logic boost_halt = sense.input_overvoltage || !good_live ||
                          sense.system_overvoltage || sense.system_short ||
                          sense.thermal_shutdown;

  always_comb begin
    // converter stops while any boost-side fault stands
    // Reverse mode keeps running: its own faults drop rb_en_next instead
    action_next.converter_run = !boost_halt || rb_en_next;
    action_next.charge_enable = !sense.battery_overvoltage && !sense.thermal_shutdown;
    action_next.termination_enable = !sense.thermal_regulation;
    action_next.safety_timer_half  = sense.thermal_regulation || icr_live ||
                                     sense.input_voltage_regulation;
    action_next.battery_switch        = !batsw_open_next;
    action_next.use_short_current     = sense.battery_short_band;
    action_next.use_precharge_current = !sense.battery_short_band;
    action_next.current_limit_pin_monitor_enable   = current_limit_pin_en_reg && !icr_live;
  end

  // ==========================================================
  // Event state and flags
  always_ff @(posedge core_clk) begin
    if (reset) begin
      // Track the live inputs in reset so release shows no false edge
      status_reg      <= status_next;
      flag_reg        <= '0;
      src_type_reg    <= sense.input_source_type;
      chg_state_reg   <= sense.charge_state;
      therm_state_reg <= sense.thermistor_state;
      powerup_reg     <= 1'b1;
    end else begin
      status_reg      <= status_next;
      flag_reg        <= flag_next;
      src_type_reg    <= sense.input_source_type;
      chg_state_reg   <= sense.charge_state;
      therm_state_reg <= sense.thermistor_state;
      powerup_reg     <= 1'b0;
    end
  end

  // Control registers written by software, plus the battery switch state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mask_reg       <= '0;
      current_limit_pin_en_reg    <= cef_pkg::CTL_RESET[cef_pkg::CTL_CURRENT_LIMIT_PIN_EN];
      rb_en_reg      <= cef_pkg::CTL_RESET[cef_pkg::CTL_RB_EN];
      batsw_open_reg <= 1'b0;
    end else begin
      if (wr_acc && hit_mask) begin
        mask_reg <= pwdata[SW-1:0];
      end
      if (wr_acc && hit_ctl) begin
        current_limit_pin_en_reg <= pwdata[cef_pkg::CTL_CURRENT_LIMIT_PIN_EN];
      end
      rb_en_reg      <= rb_en_next;
      batsw_open_reg <= batsw_open_next;
    end
  end

  // fixed-width pulse timed on core_clk
  // The count runs only while the pulse is already underway, so the low
  // time is exactly ALERT_LEN cycles whatever arrives meanwhile.
  // A slower host sees the same width; it only needs to sample the pin
  // faster than ALERT_LEN cycles to catch every pulse.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg    <= cef_pkg::ALERT_IDLE;
      cnt_reg      <= '0;
      host_alert_n <= 1'b1;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= (state_next == cef_pkg::ALERT_PULSE && state_reg == cef_pkg::ALERT_PULSE) ?
                      cnt_reg + 1'b1 : '0;
      host_alert_n <= state_next != cef_pkg::ALERT_PULSE;
    end
  end

  // Outputs registered so glitches on sense never reach the pins
  always_ff @(posedge core_clk) begin
    if (reset) begin
      action              <= '0;
      reverse_buck_enable <= 1'b0;
    end else begin
      action              <= action_next;
      reverse_buck_enable <= rb_en_next;
    end
  end

  // APB: no wait state; reads come from a flop loaded during setup
  // Ready is raised only after a setup cycle, so a master that skips setup
  // gets no answer; the read-clear of flags happens on the access edge,
  // after the word was captured, so a flag set by an event in the setup cycle is lost.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pslverr    <= 1'b0;
    end else begin
      pready_reg <= psel && !penable;
      prdata_reg <= rd_word;
      pslverr    <= psel && !penable && !hit_any;
    end
  end

  assign pready = pready_reg;
  assign prdata = prdata_reg;

endmodule

// ### sim/cef_monitor.sv
// Purpose: Port assertions for the event and fault block
// Assumes: One clock, synchronous active-high reset
// Notes:   Attached to every cef_event_ctrl by bind
`timescale 1ns/1ns
module cef_monitor #(
  parameter int ALERT_LEN = 8
) (
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 reset,
  // APB
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic                 pready,
  input wire logic [31:0]          prdata,
  input wire logic                 pslverr,
  // Sense and reactions
  input wire cef_pkg::cef_sense_t  sense,
  input wire logic                 host_alert_n,
  input wire cef_pkg::cef_action_t action,
  input wire logic                 reverse_buck_enable
);
  // ==========================================================
  // Setup
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  int low_cnt;
  // Low-time counter; a stuck alert shows up as an overrun
  always_ff @(posedge core_clk) begin
    low_cnt <= (reset || host_alert_n) ? 0 : low_cnt + 1;
  end
  // ==========================================================
  // Assertions
  pulse_len_a:
    assert property ($rose(host_alert_n) |-> low_cnt == ALERT_LEN) else $error("alert width");
  pulse_max_a:
    assert property (low_cnt <= ALERT_LEN) else $error("alert too long");
  alert_cause_a:
    assert property ($fell(host_alert_n) |-> $past(reset, 2) || $past(sense) != $past(sense, 2))
    else $error("alert without event");
  ready_a:
    assert property (psel && !penable |=> pready && penable) else $error("no ready");
  slverr_a:
    assert property (pready && paddr > 8'h10 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access");
  ov_stop_a:
    assert property (sense.input_overvoltage |=> !action.converter_run) else $error("ov run");
  sysov_stop_a:
    assert property (sense.system_overvoltage |=> !action.converter_run) else $error("sysov run");
  thermal_shutdown_stop_a:
    assert property (sense.thermal_shutdown |=> !action.converter_run) else $error("thermal_shutdown run");
  rb_clear_a:
    assert property (reverse_buck_enable && !(psel && pwrite) && (sense.output_overvoltage
      || sense.output_short || sense.thermal_shutdown) |=> !reverse_buck_enable)
    else $error("reverse enable kept");
  batov_a:
    assert property (sense.battery_overvoltage && sense.charge_state != 2'h0
      |=> !action.charge_enable) else $error("batov charge");
  // Main scenarios
  cover property ($fell(host_alert_n));
  cover property ($fell(reverse_buck_enable));
  cover property (pready && pslverr);
endmodule
bind cef_event_ctrl cef_monitor #(.ALERT_LEN(ALERT_LEN)) u_mon (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr), .sense(sense),
  .host_alert_n(host_alert_n), .action(action), .reverse_buck_enable(reverse_buck_enable));

// ### sim/cef_host_model.sv
// Purpose: Host side of the alert line
// Assumes: Host samples the line on the device clock
// Notes:   Counts finished pulses and keeps the last width
`timescale 1ns/1ns
module cef_host_model (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Alert from the device
  input  wire logic host_alert_n,
  // Observed pulses
  output int        pulses,
  output int        last_width
);
  int run;
  // Measure each low run; a reset drops a partial run
  always @(posedge core_clk) begin
    if (reset) begin
      run    <= 0;
      pulses <= 0;
    end else if (!host_alert_n) begin
      run <= run + 1;
    end else if (run != 0) begin
      pulses     <= pulses + 1;
      last_width <= run;
      run        <= 0;
    end
  end
endmodule

// ### sim/cef_event_ctrl_test.sv
// Purpose: Self-checking bench for the event and fault block
// Assumes: Short alert length for speed
// Notes:   Each scenario is one task
`timescale 1ns/1ns
`define CHK(w, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s expected %h seen %h", w, e, g); end end
module cef_event_ctrl_test;
  localparam int LEN = 8;
  logic                 core_clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic                 host_alert_n, rb_en;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rd;
  cef_pkg::cef_sense_t  sense, base;
  cef_pkg::cef_action_t action;
  int                   pulses, last_width, n_errors, checks_done;
  cef_event_ctrl #(.ALERT_LEN(LEN)) u_dut (.core_clk(core_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .sense(sense),
    .host_alert_n(host_alert_n), .action(action), .reverse_buck_enable(rb_en));
  cef_host_model u_host (.core_clk(core_clk), .reset(reset), .host_alert_n(host_alert_n),
    .pulses(pulses), .last_width(last_width));
  // ==========================================================
  // Shared tasks
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Request held until pready is seen high at a rising edge; data taken there
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    bit ok;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge core_clk);
      ok = (pready === 1'b1);
      if (ok) begin
        rd = prdata;
        err = pslverr;
      end
    end
    if (!ok) begin n_errors++; wrap_up(); end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd_chk(input string w, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(w, e, rd)
  endtask
  task automatic wait_pulse(input int n0);
    for (int i = 0; i < 200 && pulses == n0; i++) @(posedge core_clk);
    if (pulses == n0) begin n_errors++; wrap_up(); end
  endtask
  task automatic idle;
    repeat (LEN + 4) @(posedge core_clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    wait_pulse(0);
    `CHK("width", LEN, last_width)
    rd_chk("ctrl", cef_pkg::OFF_CONTROL, cef_pkg::CTL_RESET);
    rd_chk("powerup", cef_pkg::OFF_FLAG, 32'h20);
    rd_chk("cleared", cef_pkg::OFF_FLAG, 32'h0);
    rd_chk("unmapped", 8'h20, 32'h0);
    `CHK("slverr", 1'b1, err)
    $display("t_reset done");
  endtask
  task automatic t_events;
    cef_pkg::cef_sense_t s [12];
    int n;
    foreach (s[j]) s[j] = base;
    s[0].src_good = 1'b0; s[1].input_source_type = 3'h5;
    s[2].input_current_regulation = 1'b1; s[3].input_voltage_regulation = 1'b1;
    s[4].thermal_regulation = 1'b1; s[5].watchdog_expired = 1'b1;
    s[6].charge_state = 2'h3; s[7].thermistor_state = 3'h2;
    s[8].input_overvoltage = 1'b1; s[9].thermal_shutdown = 1'b1;
    s[10].battery_overvoltage = 1'b1; s[11].safety_timer_expired = 1'b1;
    for (int i = 0; i < 12; i++) begin
      n = pulses;
      sense <= s[i];
      wait_pulse(n);
      sense <= base;
      idle();
      // Input overvoltage also takes the source out of good
      rd_chk("flag", cef_pkg::OFF_FLAG, (i == 8) ? 32'h101 : 32'h1 << i);
      rd_chk("reread", cef_pkg::OFF_FLAG, 32'h0);
    end
    `CHK("resume", 1'b1, action.converter_run)
    $display("t_events done");
  endtask
  task automatic t_mask;
    int n = pulses;
    apb(1'b1, cef_pkg::OFF_MASK, 32'h4);
    sense.current_limit_pin <= 1'b1;
    idle();
    apb(1'b0, cef_pkg::OFF_STATUS, 32'h0);
    `CHK("status", 1'b1, rd[2])
    rd_chk("masked", cef_pkg::OFF_FLAG, 32'h4);
    `CHK("no pulse", n, pulses)
    apb(1'b1, cef_pkg::OFF_MASK, 32'h0);
    apb(1'b1, cef_pkg::OFF_CONTROL, 32'h0);
    sense.current_limit_pin <= 1'b0;
    idle();
    sense.current_limit_pin <= 1'b1;
    idle();
    rd_chk("pin off", cef_pkg::OFF_FLAG, 32'h0);
    `CHK("pin pulse", n, pulses)
    `CHK("monitor", 1'b0, action.current_limit_pin_monitor_enable)
    sense <= base;
    apb(1'b1, cef_pkg::OFF_CONTROL, cef_pkg::CTL_RESET);
    $display("t_mask done");
  endtask
  task automatic t_overlap;
    int n = pulses;
    sense.thermal_regulation <= 1'b1;
    repeat (3) @(posedge core_clk);
    sense.input_voltage_regulation <= 1'b1;
    wait_pulse(n);
    `CHK("width", LEN, last_width)
    `CHK("half rate", 1'b1, action.safety_timer_half)
    `CHK("term", 1'b0, action.termination_enable)
    idle();
    `CHK("one pulse", n + 1, pulses)
    rd_chk("both", cef_pkg::OFF_FLAG, 32'h18);
    sense <= base;
    idle();
    $display("t_overlap done");
  endtask
  task automatic t_rbuck;
    int n;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, cef_pkg::OFF_CONTROL, 32'h3);
      `CHK("rb on", 1'b1, rb_en)
      n = pulses;
      if (i == 0) sense.output_overvoltage <= 1'b1;
      else if (i == 1) sense.output_short <= 1'b1;
      else sense.thermal_shutdown <= 1'b1;
      wait_pulse(n);
      `CHK("rb off", 1'b0, rb_en)
      sense <= base;
      idle();
      rd_chk("fault", cef_pkg::OFF_FLAG, (i == 2) ? 32'h200 : 32'h2000);
    end
    $display("t_rbuck done");
  endtask
  task automatic t_bsw;
    sense.src_good <= 1'b0;
    sense.battery_overdischarge <= 1'b1;
    idle();
    `CHK("bsw open", 1'b0, action.battery_switch)
    sense.src_good <= 1'b1;
    idle();
    `CHK("bsw shut", 1'b1, action.battery_switch)
    sense.battery_short_band <= 1'b1;
    idle();
    `CHK("short cur", 1'b1, action.use_short_current)
    `CHK("prechg cur", 1'b0, action.use_precharge_current)
    rd_chk("actions", cef_pkg::OFF_ACTION, 32'hed);
    sense <= base;
    idle();
    $display("t_bsw done");
  endtask
  // ==========================================================
  // Clock and main sequence
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    n_errors = 0; checks_done = 0;
    base = '0; base.src_good = 1'b1; base.charge_state = 2'h1;
    sense = base; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0; reset = 1'b1;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    t_reset(); t_events(); t_mask(); t_overlap(); t_rbuck(); t_bsw();
    wrap_up();
  end
endmodule
